//--- design/crc32_byte.v
// Ethernet CRC-32 advanced by one byte, least significant bit first.
// Assumes the caller keeps the running value and inverts it to form the FCS.
`timescale 1ns/1ns
`default_nettype none
`include "switch_port_regs.vh"
module crc32_byte (
	// Running value and new byte
	input wire [31:0] crc_in,
	input wire [7:0] data,
	// Advanced value
	output reg [31:0] crc_out
);
	integer i;

	always @* begin
		crc_out = crc_in;
		for (i = 0; i < 8; i = i + 1) begin
			if (crc_out[0] ^ data[i])
				crc_out = (crc_out >> 1) ^ `CRC_POLY;
			else
				crc_out = crc_out >> 1;
		end
	end
endmodule
`default_nettype wire

//--- design/switch_port_logic.v
// Ingress priority classification, egress VLAN tag editing with FCS regeneration and
// spanning-tree gating for the three ports of a small switch.
// Assumes an APB3 master on pclk and byte streams synchronous to pclk, FCS included.
// Operation
// - A high-priority receiving port marks every frame it receives as high priority.
// - Tagged frames give their three-bit priority through the programmable map.
// - Tag priority is used only when the port's bit five is set.
// - Egress bit two adds the ingress port's default tag to untagged frames.
// - A six-bit select field chooses egress ports per source for insertion.
// - A frame that already carries a tag never gets a second one.
// - Egress bit one strips tags; untagged frames pass unchanged.
// - The tag is four bytes: protocol identifier then tag control field.
// - Any inserted or removed tag makes the FCS recomputed and replaced.
// - With re-mapping, frame priority is capped at the default tag priority.
// - Upper six ToS bits select one of 64 code point bits for priority.
// - Port 3 is the processor port; ports 1 and 2 take five states.
// - Disabled ports forward and receive nothing normal and learn nothing.
// - Blocking ports send received frames only to the processor, no learning.
// - Listening ports exchange frames only with the processor, no learning; here they share the blocking setting, so the processor cannot send to them.
// - Learning ports exchange frames only with the processor and learn.
// - Forwarding ports forward, receive and learn normally.
// - Transmit queues split by priority only when the port's bit zero is set.
// - A processor trailer byte's two low bits select the destination port.
//
// The APB slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
`include "switch_port_regs.vh"
module switch_port_logic (
	// APB slave
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output wire pready,
	output wire pslverr,
	// Ingress byte stream
	input wire in_valid,
	input wire in_sop,
	input wire in_eop,
	input wire [1:0] in_port,
	input wire [7:0] in_data,
	// Classification result
	output reg cls_valid,
	output reg [1:0] cls_prio,
	output reg cls_high,
	output reg cls_tagged,
	output reg [1:0] cls_dest,
	output reg [2:0] cls_fwd_mask,
	output reg cls_learn,
	output reg [5:0] cls_queue,
	// Egress byte stream in
	input wire e_valid,
	input wire e_sop,
	input wire e_eop,
	input wire [7:0] e_data,
	input wire [1:0] e_src,
	input wire [1:0] e_dst,
	input wire e_tagged,
	output wire e_ready,
	// Egress byte stream out
	output reg o_valid,
	output reg o_sop,
	output reg o_eop,
	output reg [7:0] o_data
);
	// ****************************************
	// Configuration registers
	// ****************************************
	reg [7:0] ctl_q [1:3];
	reg [15:0] tag_q [1:3];
	reg [6:0] stp_q;
	reg [15:0] pmap_q;
	reg [63:0] dscp_q;
	reg [5:0] sel_q;
	reg tail_q;
	reg [31:0] rd_d;
	integer n;
	integer q;

	localparam ST_PASS = 2'h0;
	localparam ST_INS = 2'h1;
	localparam ST_FCS = 2'h2;
	reg [1:0] st_q;

	// ****************************************
	// Helpers
	// ****************************************
	// Port number zero is not a port; it is folded onto the processor port.
	function [1:0] pn;
		input [1:0] p;
		begin
			pn = (p == 2'h0) ? `PORT_CPU : p;
		end
	endfunction

	// Returns {learning disable, receive enable, transmit enable}.
	function [2:0] stp_of;
		input [1:0] p;
		begin
			case (p)
			2'h1: stp_of = stp_q[2:0];
			2'h2: stp_of = stp_q[6:4];
			default: stp_of = `STP_FWD;
			endcase
		end
	endfunction

	function [1:0] pmax;
		input [1:0] a;
		input [1:0] b;
		begin
			pmax = (a > b) ? a : b;
		end
	endfunction

	function addr_ok;
		input [7:0] a;
		begin
			addr_ok = (a <= `A_STATUS) && (a[1:0] == 2'h0);
		end
	endfunction

	// Each source owns two select bits, one for each of the other two ports.
	function sel_bit;
		input [1:0] s;
		input [1:0] d;
		begin
			case ({s, d})
			4'h6: sel_bit = sel_q[0];
			4'h7: sel_bit = sel_q[1];
			4'h9: sel_bit = sel_q[2];
			4'hB: sel_bit = sel_q[3];
			4'hD: sel_bit = sel_q[4];
			4'hE: sel_bit = sel_q[5];
			default: sel_bit = 1'b0;
			endcase
		end
	endfunction

	// ****************************************
	// APB slave
	// ****************************************
	wire acc = psel & penable;
	wire wr = acc & pwrite & addr_ok(paddr);
	assign pready = 1'b1;
	assign pslverr = acc & ~addr_ok(paddr);

	always @* begin
		case (paddr)
		`A_CTL1: rd_d = {24'h0, ctl_q[1]};
		`A_CTL2: rd_d = {24'h0, ctl_q[2]};
		`A_CTL3: rd_d = {24'h0, ctl_q[3]};
		`A_STP: rd_d = {25'h0, stp_q};
		`A_TAG1: rd_d = {16'h0, tag_q[1]};
		`A_TAG2: rd_d = {16'h0, tag_q[2]};
		`A_TAG3: rd_d = {16'h0, tag_q[3]};
		`A_PMAP: rd_d = {16'h0, pmap_q};
		`A_DSCP_LO: rd_d = dscp_q[31:0];
		`A_DSCP_HI: rd_d = dscp_q[63:32];
		`A_INS_SEL: rd_d = {26'h0, sel_q};
		`A_GLOBAL: rd_d = {31'h0, tail_q};
		`A_STATUS: rd_d = {28'h0, st_q != ST_PASS, cls_tagged, cls_prio};
		default: rd_d = 32'h0;
		endcase
	end

	// Read data is caught in the setup cycle so that it leaves a flip-flop.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			prdata <= 32'h0;
		else if (psel && !penable && !pwrite)
			prdata <= rd_d;
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (n = 1; n <= 3; n = n + 1) begin
				ctl_q[n] <= `R_CTL;
				tag_q[n] <= `R_TAG;
			end
			stp_q <= `R_STP;
			pmap_q <= `R_PMAP;
			dscp_q <= `R_DSCP;
			sel_q <= `R_SEL;
			tail_q <= 1'b0;
		end else if (wr) begin
			case (paddr)
			`A_CTL1: ctl_q[1] <= pwdata[7:0];
			`A_CTL2: ctl_q[2] <= pwdata[7:0];
			`A_CTL3: ctl_q[3] <= pwdata[7:0];
			`A_STP: stp_q <= pwdata[6:0];
			`A_TAG1: tag_q[1] <= pwdata[15:0];
			`A_TAG2: tag_q[2] <= pwdata[15:0];
			`A_TAG3: tag_q[3] <= pwdata[15:0];
			`A_PMAP: pmap_q <= pwdata[15:0];
			`A_DSCP_LO: dscp_q[31:0] <= pwdata;
			`A_DSCP_HI: dscp_q[63:32] <= pwdata;
			`A_INS_SEL: sel_q <= pwdata[5:0];
			`A_GLOBAL: tail_q <= pwdata[`F_TAIL];
			default: ;
			endcase
		end
	end

	// ****************************************
	// Ingress classifier
	// ****************************************
	reg [4:0] ci_q;
	reg [1:0] cp_q;
	reg [2:0] cs_q;
	reg [15:0] ctp_q;
	reg [7:0] ctci_q;
	reg [7:0] ctos_u_q;
	reg [15:0] cet_q;
	reg [7:0] ctos_t_q;
	reg [31:0] ctail_q;
	wire [4:0] ci = in_sop ? 5'h0 : ci_q;

	// Header bytes are captured by position; the index saturates past the header.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ci_q <= 5'h0;
			cp_q <= `PORT_CPU;
			cs_q <= `STP_FWD;
			ctp_q <= 16'h0;
			ctci_q <= 8'h0;
			ctos_u_q <= 8'h0;
			cet_q <= 16'h0;
			ctos_t_q <= 8'h0;
			ctail_q <= 32'h0;
		end else if (in_valid) begin
			ci_q <= (ci == `O_LAST) ? ci : ci + 5'h1;
			ctail_q <= {ctail_q[23:0], in_data};
			if (in_sop) begin
				cp_q <= pn(in_port);
				cs_q <= stp_of(pn(in_port));
			end
			case (ci)
			`O_TPID_HI: ctp_q[15:8] <= in_data;
			`O_TPID_LO: ctp_q[7:0] <= in_data;
			`O_TCI: ctci_q <= in_data;
			`O_TOS_U: ctos_u_q <= in_data;
			`O_ET_HI: cet_q[15:8] <= in_data;
			`O_ET_LO: cet_q[7:0] <= in_data;
			`O_TOS_T: ctos_t_q <= in_data;
			default: ;
			endcase
		end
	end

	wire c_tag = (ctp_q == `TPID);
	wire [7:0] c_ctl = ctl_q[cp_q];
	wire [2:0] c_ceil = tag_q[cp_q][15:13];
	wire c_cap = c_ctl[`F_REMAP] && (ctci_q[7:5] > c_ceil);
	wire [2:0] c_up = c_cap ? c_ceil : ctci_q[7:5];
	wire [1:0] c_p1 = pmap_q[{c_up, 1'b0} +: 2];
	wire c_use1p = c_ctl[`F_1P] && c_tag;
	wire [7:0] c_tos = c_tag ? ctos_t_q : ctos_u_q;
	wire c_ip = ((c_tag ? cet_q : ctp_q) == `ET_IP);
	wire c_usedscp = c_ctl[`F_DSCP] && c_ip;
	wire [1:0] c_pd = dscp_q[c_tos[7:2]] ? `PRIO_TOP : 2'h0;
	// The trailer sits just before the four FCS bytes, so at the last byte it is
	// the oldest of the four bytes held behind the current one.
	wire c_tt = tail_q && (cp_q == `PORT_CPU);
	wire [7:0] c_trl = ctail_q[31:24];
	wire [1:0] c_pp = c_ctl[`F_PPRIO];
	wire [1:0] c_pa = pmax(c_pp, c_use1p ? c_p1 : 2'h0);
	wire [1:0] c_pb = pmax(c_usedscp ? c_pd : 2'h0, c_tt ? c_trl[3:2] : 2'h0);
	wire [1:0] c_prio = pmax(c_pa, c_pb);
	wire [2:0] c_self = 3'h1 << (cp_q - 2'h1);
	// Disabled, blocking and listening share one setting, so the port behaves alike
	// in all three; static override frames are delivered by the lookup, not here.
	wire [2:0] c_mask = cs_q[`F_RXEN] ? (`ALL_PORTS & ~c_self) : `CPU_MASK;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cls_valid <= 1'b0;
			cls_prio <= 2'h0;
			cls_high <= 1'b0;
			cls_tagged <= 1'b0;
			cls_dest <= 2'h0;
			cls_fwd_mask <= 3'h0;
			cls_learn <= 1'b0;
			cls_queue <= 6'h0;
		end else begin
			cls_valid <= in_valid && in_eop;
			if (in_valid && in_eop) begin
				cls_prio <= c_prio;
				cls_high <= c_prio[1];
				cls_tagged <= c_tag;
				cls_dest <= c_tt ? c_trl[1:0] : 2'h0;
				cls_fwd_mask <= c_mask;
				cls_learn <= !cs_q[`F_LDIS];
				for (q = 0; q < 3; q = q + 1)
					cls_queue[2 * q +: 2] <= ctl_q[q + 1][`F_SPLIT] ? c_prio : 2'h0;
			end
		end
	end

	// ****************************************
	// Egress tag editor
	// ****************************************
	// Bytes wait in a four-byte window so that the incoming FCS is known only when
	// the last byte arrives and can then be replaced.
	reg [31:0] w_q;
	reg [2:0] wc_q;
	reg [4:0] oi_q;
	reg [1:0] k_q;
	reg [31:0] crc_q;
	wire [31:0] crc_n;
	reg [1:0] es_q;
	reg ins_q;
	reg rem_q;
	reg rm_q;
	reg mod_q;
	reg drop_q;
	reg em_v;
	reg [7:0] em_d;

	wire [1:0] e_s = pn(e_src);
	wire [1:0] e_d = pn(e_dst);
	wire [2:0] e_st = stp_of(e_d);
	// Only the processor may reach a port that is learning; no source reaches one with learning disabled and transmit off.
	wire e_txok = e_st[`F_TXEN] || (e_s == `PORT_CPU && !e_st[`F_LDIS]);
	wire e_ins = !e_tagged && ctl_q[e_d][`F_INSERT] && sel_bit(e_s, e_d);
	wire e_rem = e_tagged && ctl_q[e_d][`F_REMOVE];
	wire e_rm = e_tagged && !e_rem && ctl_q[e_s][`F_REMAP];
	wire [2:0] e_ceil = tag_q[es_q][15:13];
	wire [31:0] e_tag = {`TPID, tag_q[es_q]};

	assign e_ready = (st_q == ST_PASS);
	wire e_take = e_valid && e_ready;
	wire e_out = e_take && !e_sop && (wc_q == `N_WIN);
	wire e_skip = rem_q && (oi_q >= `O_TPID_HI) && (oi_q <= `O_TOS_U);
	wire em_ok = em_v && !drop_q;

	always @* begin
		em_v = 1'b0;
		em_d = w_q[31:24];
		case (st_q)
		ST_PASS: begin
			em_v = e_out && !e_skip;
			if (rm_q && (oi_q == `O_TCI) && (w_q[31:29] > e_ceil))
				em_d = {e_ceil, w_q[28:24]};
		end
		ST_INS: begin
			em_v = 1'b1;
			em_d = e_tag[{~k_q, 3'b000} +: 8];
		end
		ST_FCS: begin
			em_v = 1'b1;
			if (mod_q)
				em_d = ~crc_q[{k_q, 3'b000} +: 8];
		end
		default: em_v = 1'b0;
		endcase
	end

	crc32_byte u_crc (
		.crc_in(crc_q),
		.data(em_d),
		.crc_out(crc_n)
	);

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q <= ST_PASS;
			w_q <= 32'h0;
			wc_q <= 3'h0;
			oi_q <= 5'h0;
			k_q <= 2'h0;
			crc_q <= `CRC_INIT;
			es_q <= `PORT_CPU;
			ins_q <= 1'b0;
			rem_q <= 1'b0;
			rm_q <= 1'b0;
			mod_q <= 1'b0;
			drop_q <= 1'b0;
			o_valid <= 1'b0;
			o_sop <= 1'b0;
			o_eop <= 1'b0;
			o_data <= 8'h0;
		end else begin
			o_valid <= em_ok;
			o_sop <= em_ok && (st_q == ST_PASS) && (oi_q == 5'h0);
			o_eop <= em_ok && (st_q == ST_FCS) && (k_q == `N_TAG);
			o_data <= em_d;
			case (st_q)
			ST_PASS: if (e_take) begin
				w_q <= {w_q[23:0], e_data};
				if (e_sop) begin
					wc_q <= 3'h1;
					oi_q <= 5'h0;
					k_q <= 2'h0;
					crc_q <= `CRC_INIT;
					es_q <= e_s;
					ins_q <= e_ins;
					rem_q <= e_rem;
					rm_q <= e_rm;
					mod_q <= e_ins || e_rem;
					drop_q <= !e_txok;
				end else begin
					if (wc_q != `N_WIN)
						wc_q <= wc_q + 3'h1;
					if (e_out) begin
						oi_q <= (oi_q == `O_LAST) ? oi_q : oi_q + 5'h1;
						if (em_v)
							crc_q <= crc_n;
						if (em_d != w_q[31:24])
							mod_q <= 1'b1;
					end
					if (e_eop)
						st_q <= ST_FCS;
					else if (e_out && ins_q && (oi_q == `O_INS_AT))
						st_q <= ST_INS;
				end
			end
			ST_INS: begin
				crc_q <= crc_n;
				k_q <= k_q + 2'h1;
				if (k_q == `N_TAG)
					st_q <= ST_PASS;
			end
			ST_FCS: begin
				w_q <= {w_q[23:0], 8'h00};
				k_q <= k_q + 2'h1;
				if (k_q == `N_TAG) begin
					st_q <= ST_PASS;
					wc_q <= 3'h0;
				end
			end
			default: st_q <= ST_PASS;
			endcase
		end
	end
endmodule
`default_nettype wire

//--- design/switch_port_regs.vh
// Register map, field positions, reset values and frame offsets of the switch port logic.
// Assumes byte addresses on an APB bus with 32-bit data, one register per aligned word.
`ifndef SWITCH_PORT_REGS_VH
`define SWITCH_PORT_REGS_VH
// ****************************************
// Register byte addresses
// ****************************************
`define A_CTL1 8'h00
`define A_CTL2 8'h04
`define A_CTL3 8'h08
`define A_STP 8'h0C
`define A_TAG1 8'h10
`define A_TAG2 8'h14
`define A_TAG3 8'h18
`define A_PMAP 8'h1C
`define A_DSCP_LO 8'h20
`define A_DSCP_HI 8'h24
`define A_INS_SEL 8'h28
`define A_GLOBAL 8'h2C
`define A_STATUS 8'h30
// ****************************************
// Field positions
// ****************************************
`define F_SPLIT 0
`define F_REMOVE 1
`define F_INSERT 2
`define F_PPRIO 4:3
`define F_1P 5
`define F_DSCP 6
`define F_REMAP 7
`define F_TXEN 0
`define F_RXEN 1
`define F_LDIS 2
`define F_TAIL 0
// ****************************************
// Reset values
// ****************************************
`define R_CTL 8'h00
`define R_STP 7'h33
`define R_TAG 16'h0001
`define R_PMAP 16'hFA50
`define R_DSCP 64'h0
`define R_SEL 6'h3F
// ****************************************
// Frame layout and port constants
// ****************************************
`define TPID 16'h8100
`define ET_IP 16'h0800
`define O_TPID_HI 5'h0C
`define O_TPID_LO 5'h0D
`define O_TCI 5'h0E
`define O_TOS_U 5'h0F
`define O_ET_HI 5'h10
`define O_ET_LO 5'h11
`define O_TOS_T 5'h13
`define O_INS_AT 5'h0B
`define O_LAST 5'h1F
`define N_WIN 3'h4
`define N_TAG 2'h3
`define CRC_INIT 32'hFFFFFFFF
`define CRC_POLY 32'hEDB88320
`define PRIO_TOP 2'h3
`define PORT_CPU 2'h3
`define STP_FWD 3'h3
`define ALL_PORTS 3'h7
`define CPU_MASK 3'h4
`endif

//--- verification/link_partner.sv
// Far side model: link partners and processor feeding both byte streams, plus output capture.
// Assumes the bench loads fb before each send and calls tasks right after a rising edge.
`timescale 1ns/1ns
`default_nettype none
module link_partner (
	input wire logic pclk,
	output logic in_valid, in_sop, in_eop,
	output logic [1:0] in_port,
	output logic [7:0] in_data,
	output logic e_valid, e_sop, e_eop, e_tagged,
	output logic [1:0] e_src, e_dst,
	output logic [7:0] e_data,
	input wire logic e_ready, o_valid,
	input wire logic [7:0] o_data
);
	logic [7:0] fb [0:127];
	logic [7:0] got [$];
	initial begin
		{in_valid, in_sop, in_eop, in_port, in_data} = 13'h0000;
		{e_valid, e_sop, e_eop, e_tagged, e_src, e_dst, e_data} = 16'h0000;
	end
	always @(posedge pclk) begin
		if (o_valid === 1'h1) got.push_back(o_data);
	end
	// Released data lines show the inverse of the last byte, so nothing stale looks valid.
	task automatic send_in(input logic [1:0] p, input int n);
		for (int i = 0; i < n; i++) begin
			@(posedge pclk);
			{in_valid, in_sop, in_eop, in_port, in_data} <= {1'h1, i == 0, i == n - 1, p, fb[i]};
		end
		@(posedge pclk);
		{in_valid, in_sop, in_eop, in_data} <= {3'h0, ~fb[n - 1]};
	endtask
	// The bench never offers processor frames toward a disabled or blocking port.
	// Static override entries live in the lookup outside this block, so none are kept.
	task automatic send_eg(input logic [1:0] s, d, input logic t, input int n);
		int i;
		i = 0;
		@(posedge pclk);
		while (i < n) begin
			{e_valid, e_sop, e_eop, e_data} <= {1'h1, i == 0, i == n - 1, fb[i]};
			{e_src, e_dst, e_tagged} <= {s, d, t};
			// The byte counts as taken only at the edge where ready is sampled high.
			@(posedge pclk);
			if (e_ready === 1'h1) i++;
		end
		{e_valid, e_sop, e_eop, e_data} <= {3'h0, ~fb[n - 1]};
	endtask
endmodule
`default_nettype wire

//--- verification/port_checker_assertions.sv
// Concurrent checks on the switch port logic, attached by bind.
// Assumes one pclk domain with presetn as asynchronous active-low reset.
`timescale 1ns/1ns
`default_nettype none
`include "switch_port_regs.vh"
module port_checker (
	input wire logic pclk, presetn,
	input wire logic in_valid, in_eop, cls_valid, cls_high, cls_learn,
	input wire logic [1:0] cls_prio,
	input wire logic [2:0] cls_fwd_mask,
	input wire logic e_valid, e_eop, e_ready, o_valid, o_sop, o_eop
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	// Set from a frame start until its end, so a second start inside a frame is caught.
	logic open_q;
	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			open_q <= 1'b0;
		else if (o_valid && o_eop)
			open_q <= 1'b0;
		else if (o_valid && o_sop)
			open_q <= 1'b1;
	end
	sequence eg_last_s;
		e_valid && e_ready && e_eop;
	endsequence
	sequence out_open_s;
		o_valid && o_sop;
	endsequence
	sequence out_close_s;
		o_valid && o_eop;
	endsequence
	cls_timing_a: assert property (in_valid && in_eop |=> cls_valid)
		else $error("no result after last ingress byte");
	cls_pulse_a: assert property (cls_valid |=> !cls_valid)
		else $error("result strobe longer than one cycle");
	high_bit_a: assert property (cls_valid |-> cls_high == cls_prio[1])
		else $error("high flag disagrees with priority");
	cls_hold_a: assert property (!cls_valid |-> $stable({cls_prio, cls_learn, cls_fwd_mask}))
		else $error("result changed without strobe");
	blocked_cpu_a: assert property (cls_valid && !cls_learn |-> cls_fwd_mask == `CPU_MASK)
		else $error("non-learning port forwards beyond processor");
	fcs_drain_a: assert property (eg_last_s |=> !e_ready [*4] ##1 e_ready)
		else $error("egress stall after last byte is not four cycles");
	frame_close_a: assert property (out_open_s |-> ##[1:300] out_close_s)
		else $error("output frame never closed");
	one_sop_a: assert property (out_open_s |-> !open_q)
		else $error("second frame start before frame end");
endmodule
bind switch_port_logic port_checker port_checker_inst (.pclk(pclk), .presetn(presetn),
	.in_valid(in_valid), .in_eop(in_eop), .cls_valid(cls_valid), .cls_high(cls_high),
	.cls_learn(cls_learn), .cls_prio(cls_prio), .cls_fwd_mask(cls_fwd_mask),
	.e_valid(e_valid), .e_eop(e_eop), .e_ready(e_ready), .o_valid(o_valid),
	.o_sop(o_sop), .o_eop(o_eop));
`default_nettype wire

//--- verification/testbench.sv
// Self-checking bench: registers over APB, ingress classification, egress tag editing.
// Assumes the design header on the include path and the link partner model.
`timescale 1ns/1ns
`default_nettype none
`include "switch_port_regs.vh"
module testbench;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, ok, er;
	logic [7:0] paddr, in_data, e_data, o_data;
	logic [31:0] pwdata, prdata, rd;
	logic in_valid, in_sop, in_eop, e_valid, e_sop, e_eop, e_tagged, e_ready;
	logic [1:0] in_port, e_src, e_dst, cls_prio, cls_dest;
	logic cls_valid, cls_high, cls_tagged, cls_learn, o_valid, o_sop, o_eop;
	logic [2:0] cls_fwd_mask;
	logic [5:0] cls_queue;
	logic [7:0] fr [0:127];
	logic [7:0] ex [0:127];
	int n_errors, tests_run;
	switch_port_logic switch_port_logic_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .in_valid(in_valid), .in_sop(in_sop),
		.in_eop(in_eop), .in_port(in_port), .in_data(in_data), .cls_valid(cls_valid),
		.cls_prio(cls_prio), .cls_high(cls_high), .cls_tagged(cls_tagged),
		.cls_dest(cls_dest), .cls_fwd_mask(cls_fwd_mask), .cls_learn(cls_learn),
		.cls_queue(cls_queue), .e_valid(e_valid), .e_sop(e_sop), .e_eop(e_eop),
		.e_data(e_data), .e_src(e_src), .e_dst(e_dst), .e_tagged(e_tagged),
		.e_ready(e_ready), .o_valid(o_valid), .o_sop(o_sop), .o_eop(o_eop), .o_data(o_data));
	link_partner link_partner_inst (.pclk(pclk), .in_valid(in_valid), .in_sop(in_sop),
		.in_eop(in_eop), .in_port(in_port), .in_data(in_data), .e_valid(e_valid),
		.e_sop(e_sop), .e_eop(e_eop), .e_tagged(e_tagged), .e_src(e_src), .e_dst(e_dst),
		.e_data(e_data), .e_ready(e_ready), .o_valid(o_valid), .o_data(o_data));
	initial begin
		pclk = 1'h0;
		forever #25 pclk = ~pclk;
	end
	task automatic chk(input logic [31:0] seen, exp);
		tests_run++;
		if (seen !== exp) begin
			n_errors++;
			$display("BAD t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		{psel, penable, pwrite, paddr, pwdata} <= {2'h2, w, a, d};
		@(posedge pclk);
		penable <= 1'h1;
		do begin
			@(posedge pclk);
			{ok, er, rd} = {pready, pslverr, prdata};
		end while (ok !== 1'h1);
		{psel, penable} <= 2'h0;
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
		apb(1'h0, a, 32'h0000_0000);
		chk(rd, exp);
	endtask
	task automatic seal(input int n);
		logic [31:0] c;
		c = `CRC_INIT;
		for (int i = 0; i < n; i++) begin
			c = c ^ ex[i];
			repeat (8) c = c[0] ? (c >> 1) ^ `CRC_POLY : c >> 1;
		end
		{ex[n + 3], ex[n + 2], ex[n + 1], ex[n]} = ~c;
	endtask
	task automatic mk(input int n, input logic tg, input logic [15:0] tci, input logic [7:0] tos);
		for (int i = 0; i < 128; i++) ex[i] = 8'h20 + i[7:0];
		if (tg) {ex[12], ex[13], ex[14], ex[15], ex[16], ex[17], ex[19]} = {`TPID, tci, `ET_IP, tos};
		else {ex[12], ex[13], ex[15]} = {`ET_IP, tos};
		seal(n - 4);
		for (int i = 0; i < 128; i++) fr[i] = ex[i];
		for (int i = 0; i < 128; i++) link_partner_inst.fb[i] = ex[i];
	endtask
	task automatic cls(input logic [1:0] p, input logic tg, input logic [15:0] tci, input logic [7:0] tos);
		mk(24, tg, tci, tos);
		link_partner_inst.send_in(p, 24);
		@(negedge pclk);
		chk(cls_valid, 1'h1);
	endtask
	// Mode 0 expects the frame unchanged, 1 a tag inserted, 2 the tag removed, 3 nothing.
	task automatic eg(input logic [1:0] s, d, input logic tg, input int mode, input logic [15:0] tci);
		int m;
		mk(64, tg, 16'h2003, 8'h00);
		link_partner_inst.got.delete();
		m = 64;
		if (mode == 1) begin
			{ex[12], ex[13], ex[14], ex[15]} = {`TPID, tci};
			for (int i = 12; i < 60; i++) ex[i + 4] = fr[i];
			m = 68;
			seal(64);
		end else if (mode == 2) begin
			for (int i = 16; i < 60; i++) ex[i - 4] = fr[i];
			m = 60;
			seal(56);
		end else if (mode == 3) begin
			m = 0;
		end
		link_partner_inst.send_eg(s, d, tg, 64);
		repeat (12) @(posedge pclk);
		chk(link_partner_inst.got.size(), m);
		for (int i = 0; i < m; i++) chk(link_partner_inst.got[i], ex[i]);
	endtask
	task automatic t_regs;
		rchk(`A_STP, 32'h0000_0033);
		rchk(`A_PMAP, 32'h0000_FA50);
		rchk(`A_INS_SEL, 32'h0000_003F);
		rchk(`A_TAG1, 32'h0000_0001);
		rchk(`A_CTL1, 32'h0000_0000);
		apb(1'h1, 8'h34, 32'hFFFF_FFFF);
		chk(er, 1'h1);
	endtask
	task automatic t_port;
		apb(1'h1, `A_CTL2, 32'h0000_0001);
		apb(1'h1, `A_CTL1, 32'h0000_0018);
		cls(2'h1, 1'h0, 16'h0000, 8'h00);
		chk({cls_high, cls_prio}, 3'h7);
		chk(cls_queue, 6'h0C);
		apb(1'h1, `A_CTL1, 32'h0000_0030);
		cls(2'h1, 1'h1, 16'h4001, 8'h00);
		chk(cls_prio, 2'h2);
	endtask
	task automatic t_1p;
		apb(1'h1, `A_CTL2, 32'h0000_0020);
		for (int p = 0; p < 8; p++) begin
			cls(2'h2, 1'h1, {p[2:0], 13'h0001}, 8'h00);
			chk(cls_prio, 2'(`R_PMAP >> (2 * p)));
		end
		apb(1'h1, `A_CTL2, 32'h0000_0000);
		cls(2'h2, 1'h1, 16'hE001, 8'h00);
		chk({cls_tagged, cls_prio}, 3'h4);
	endtask
	task automatic t_remap;
		apb(1'h1, `A_TAG2, 32'h0000_4001);
		apb(1'h1, `A_CTL2, 32'h0000_00A0);
		cls(2'h2, 1'h1, 16'hE001, 8'h00);
		chk(cls_prio, 2'(`R_PMAP >> 4));
	endtask
	task automatic t_dscp;
		apb(1'h1, `A_CTL3, 32'h0000_0040);
		apb(1'h1, `A_DSCP_HI, 32'h8000_0000);
		cls(2'h3, 1'h0, 16'h0000, 8'hFC);
		chk(cls_prio, 2'h3);
		cls(2'h3, 1'h0, 16'h0000, 8'hF8);
		chk(cls_prio, 2'h0);
	endtask
	task automatic t_tail;
		apb(1'h1, `A_GLOBAL, 32'h0000_0001);
		mk(24, 1'h0, 16'h0000, 8'h00);
		link_partner_inst.fb[19] = 8'h0E;
		link_partner_inst.send_in(2'h3, 24);
		@(negedge pclk);
		chk({cls_dest, cls_prio}, 4'hB);
		rchk(`A_STATUS, 32'h0000_0003);
	endtask
	task automatic t_stp;
		apb(1'h1, `A_STP, 32'h0000_0034);
		cls(2'h1, 1'h0, 16'h0000, 8'h00);
		chk({cls_learn, cls_fwd_mask}, {1'h0, `CPU_MASK});
		apb(1'h1, `A_STP, 32'h0000_0030);
		cls(2'h1, 1'h0, 16'h0000, 8'h00);
		chk({cls_learn, cls_fwd_mask}, {1'h1, `CPU_MASK});
		apb(1'h1, `A_STP, 32'h0000_0033);
		cls(2'h1, 1'h0, 16'h0000, 8'h00);
		chk({cls_learn, cls_fwd_mask}, 4'hE);
	endtask
	task automatic t_tags;
		apb(1'h1, `A_CTL2, 32'h0000_0004);
		apb(1'h1, `A_TAG1, 32'h0000_A005);
		eg(2'h1, 2'h2, 1'h0, 1, 16'hA005);
		eg(2'h1, 2'h2, 1'h1, 0, 16'hA005);
		apb(1'h1, `A_INS_SEL, 32'h0000_003E);
		eg(2'h1, 2'h2, 1'h0, 0, 16'hA005);
		apb(1'h1, `A_CTL3, 32'h0000_0002);
		eg(2'h2, 2'h3, 1'h1, 2, 16'h0000);
		eg(2'h2, 2'h3, 1'h0, 0, 16'h0000);
		apb(1'h1, `A_STP, 32'h0000_0003);
		eg(2'h3, 2'h2, 1'h1, 0, 16'h0000);
		eg(2'h1, 2'h2, 1'h0, 3, 16'h0000);
	endtask
	task automatic wrap_up;
		$display("compares %0d mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	initial begin
		#1_000_000;
		n_errors++;
		wrap_up;
	end
	initial begin
		{psel, penable, pwrite, paddr, pwdata} = 43'h0;
		presetn = 1'h0;
		n_errors = 0;
		tests_run = 0;
		repeat (5) @(posedge pclk);
		presetn <= 1'h1;
		t_regs;
		t_port;
		t_1p;
		t_remap;
		t_dscp;
		t_tail;
		t_stp;
		t_tags;
		wrap_up;
	end
endmodule
`default_nettype wire
